// ==== cbd_pkg.sv ====
package cbd_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_RANGE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_CHAN = 8'h14;
  localparam logic [7:0] OFF_INFO = 8'h18;

  // Control byte fields, as vector positions (printed bit 0 is the leftmost).
  localparam int CTL_IRQ = 7;
  localparam int CTL_VALID = 6;
  localparam int CTL_LB = 5;

  // Status byte 7 fields.
  localparam int S7_IRQ = 6;
  localparam int S7_DONE = 4;
  localparam int S7_PRG5 = 2;
  localparam int S7_PRG6 = 1;

  // Status byte 6 fields.
  localparam int S6_RESID = 5;
  localparam int S6_NAK = 2;
  localparam int S6_PERR = 1;
  localparam int S6_UERR = 0;

  // Channel control register fields.
  localparam int CHN_STOP = 0;
  localparam int CHN_TX = 1;
  localparam int CHN_LVL = 2;
  localparam int LVL_W = 3;

  // Reset value of every descriptor byte.
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Byte lane enables on the word-wide memory bus.
  localparam logic [1:0] BE_LEFT = 2'b10;
  localparam logic [1:0] BE_RIGHT = 2'b01;

  // Engine states, Gray coded along idle, memory, completion.
  typedef enum logic [1:0] {
    CBD_IDLE = 2'b00,
    CBD_MEM = 2'b01,
    CBD_CPL = 2'b11
  } cbd_state_e;

endpackage

// ==== cbd_engine.sv ====
// Summary of operation
// - Buffer may start and end on the left or right byte of a word.
// - Buffer bytes are handled in ascending address order, first character lowest.
// - Address field advances only when a character physically moves.
// - Range field drops by one on every load or store, skipped or physical, made while it is nonzero.
// - Next-block instruction advances the active pointer, activating that descriptor.
// - Active descriptor is engine-only; program sees only valid and last-block bits.
// - Receive: address points at the byte for the next received character.
// - Transmit: address points at the next byte to fetch.
// - Processing runs until range is zero, or ends early by next-block or stop on receive or transmit.
// - Remaining range equals the bytes never transferred.
// - Completion writes both status bytes and sets the complete flag.
// - Next-block while a descriptor is active completes that descriptor.
// - Program bits 5 and 6 are copied into completed status byte 7.
// - Software stop command completes the current descriptor.
// - Memory negative acknowledge completes the descriptor and sets status 6 bit 5.
// - Parity error on returned data completes and sets status 6 bit 6.
// - Uncorrected memory error completes and sets status 6 bit 7.
// - One character moves per transfer step between program and buffer.
// - Completing a used descriptor clears its valid bit.
// - Interrupt on completion if requested and a level is assigned.
// - Control write clears status; usable only after address/range and control writes.
module cbd_engine #(
  parameter int NDESC = 4,
  parameter int AW = 24,
  parameter int RW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [AW-2:0] mem_addr,
  output logic [1:0] mem_be,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_nak,
  input wire logic mem_perr,
  input wire logic mem_uerr,
  output logic cp_ready,
  input wire logic cp_load,
  input wire logic cp_store,
  input wire logic cp_phys,
  input wire logic [7:0] cp_wchar,
  input wire logic cp_next_block,
  input wire logic [1:0] cp_lt_bits,
  output logic [7:0] cp_rchar,
  output logic cp_done,
  output logic cp_valid,
  output logic cp_last_block,
  output logic cp_last_char,
  output logic irq_req,
  output logic [cbd_pkg::LVL_W-1:0] irq_level
);

  localparam int IW = $clog2(NDESC);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  cbd_pkg::cbd_state_e st_q;
  logic [AW-1:0] d_addr_q [NDESC];
  logic [RW-1:0] d_rng_q [NDESC];
  logic [7:0] d_ctl_q [NDESC];
  logic [7:0] d_s6_q [NDESC];
  logic [7:0] d_s7_q [NDESC];
  logic d_ar_q [NDESC];
  logic [IW-1:0] sel_q;
  logic [IW-1:0] act_q;
  logic chan_tx_q;
  logic [cbd_pkg::LVL_W-1:0] lvl_q;
  logic stop_q;
  logic cpl_nb_q;
  logic [2:0] cpl_err_q;
  logic [1:0] lt_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic apb_err;
  logic apb_wr;
  logic act_valid;
  logic rdy;
  logic cmd;
  logic acc;
  logic nb_go;
  logic nb_skip;
  logic stop_go;
  logic fail_any;
  logic [2:0] fail_v;
  logic [AW-1:0] act_addr;
  logic [RW-1:0] act_rng;
  logic done_q;
  logic last_char_q;
  logic irq_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [AW-2:0] mem_addr_q;
  logic [1:0] mem_be_q;
  logic [15:0] mem_wdata_q;
  logic [7:0] rchar_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Picks the byte lane enables from the lowest address bit.
  function automatic logic [1:0] cbd_lane(input logic a0);
    cbd_lane = a0 ? cbd_pkg::BE_RIGHT : cbd_pkg::BE_LEFT;
  endfunction

  // Steps a descriptor index around the ring.
  function automatic logic [IW-1:0] cbd_next(input logic [IW-1:0] ix);
    cbd_next = ix + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode for the channel program port.

  // The program only sees valid and last-block of the active descriptor.
  assign act_valid = d_ctl_q[act_q][cbd_pkg::CTL_VALID];
  assign act_addr = d_addr_q[act_q];
  assign act_rng = d_rng_q[act_q];
  assign rdy = (st_q == cbd_pkg::CBD_IDLE) && !stop_q;
  assign cmd = rdy && (cp_load || cp_store) && !cp_next_block;
  assign acc = cmd && act_valid;
  assign nb_go = rdy && cp_next_block && act_valid;
  assign nb_skip = rdy && cp_next_block && !act_valid;
  assign stop_go = (st_q == cbd_pkg::CBD_IDLE) && stop_q && act_valid;
  // Parity only matters on data coming back to the engine.
  assign fail_v = {mem_nak, mem_perr && !mem_we_q, mem_uerr};
  assign fail_any = (st_q == cbd_pkg::CBD_MEM) && (|fail_v);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped or active-owned targets.

  assign apb_wr = psel && penable && pwrite && !apb_err;

  // Decodes the address and refuses setup writes to the active descriptor.
  always_comb begin
    apb_err = 1'b0;
    rd_d = '0;
    case (paddr)
      cbd_pkg::OFF_SEL: rd_d[IW-1:0] = sel_q;
      cbd_pkg::OFF_ADDR: begin
        rd_d[AW-1:0] = d_addr_q[sel_q];
        apb_err = pwrite && sel_q == act_q && act_valid;
      end
      cbd_pkg::OFF_RANGE: begin
        rd_d[RW-1:0] = d_rng_q[sel_q];
        apb_err = pwrite && sel_q == act_q && act_valid;
      end
      cbd_pkg::OFF_CTRL: begin
        rd_d[7:0] = d_ctl_q[sel_q];
        apb_err = pwrite && sel_q == act_q && act_valid;
      end
      cbd_pkg::OFF_STAT: rd_d[15:0] = {d_s7_q[sel_q], d_s6_q[sel_q]};
      cbd_pkg::OFF_CHAN: begin
        rd_d[cbd_pkg::CHN_TX] = chan_tx_q;
        rd_d[cbd_pkg::CHN_LVL +: cbd_pkg::LVL_W] = lvl_q;
      end
      cbd_pkg::OFF_INFO: begin
        rd_d[IW-1:0] = act_q;
        rd_d[IW] = act_valid;
        rd_d[IW+2 -: 2] = st_q;
      end
      default: apb_err = 1'b1;
    endcase
  end

  // Read data is captured in the setup phase and shown in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= rd_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && apb_err;

  // Channel control: direction, interrupt level and selector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_tx_q <= 1'b0;
      lvl_q <= '0;
      sel_q <= '0;
    end else if (apb_wr) begin
      if (paddr == cbd_pkg::OFF_CHAN) begin
        chan_tx_q <= pwdata[cbd_pkg::CHN_TX];
        lvl_q <= pwdata[cbd_pkg::CHN_LVL +: cbd_pkg::LVL_W];
      end
      if (paddr == cbd_pkg::OFF_SEL) begin
        sel_q <= pwdata[IW-1:0];
      end
    end
  end

  // A new stop wins over the consumption of an older one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= (apb_wr && paddr == cbd_pkg::OFF_CHAN && pwdata[cbd_pkg::CHN_STOP])
                || (stop_q && st_q != cbd_pkg::CBD_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine state machine.

  // Idle takes one command, memory waits for the answer, completion lasts a cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= cbd_pkg::CBD_IDLE;
    end else begin
      case (st_q)
        cbd_pkg::CBD_IDLE: begin
          if (nb_go || stop_go) begin
            st_q <= cbd_pkg::CBD_CPL;
          end else if (acc && cp_phys) begin
            st_q <= cbd_pkg::CBD_MEM;
          end
        end
        cbd_pkg::CBD_MEM: begin
          if (fail_any) begin
            st_q <= cbd_pkg::CBD_CPL;
          end else if (mem_ack) begin
            st_q <= cbd_pkg::CBD_IDLE;
          end
        end
        cbd_pkg::CBD_CPL: st_q <= cbd_pkg::CBD_IDLE;
        default: st_q <= cbd_pkg::CBD_IDLE;
      endcase
    end
  end

  // Records why the active descriptor is being completed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_nb_q <= 1'b0;
      cpl_err_q <= '0;
      lt_q <= '0;
    end else if (nb_go || stop_go) begin
      cpl_nb_q <= nb_go;
      cpl_err_q <= '0;
      lt_q <= nb_go ? cp_lt_bits : 2'b00;
    end else if (fail_any) begin
      cpl_nb_q <= 1'b0;
      cpl_err_q <= fail_v;
      lt_q <= '0;
    end
  end

  // Active pointer moves on a next-block, at once or after completing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= '0;
    end else if (nb_skip || (st_q == cbd_pkg::CBD_CPL && cpl_nb_q)) begin
      act_q <= cbd_next(act_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor store: software setup and engine updates.

  // Setup writes go to the selected entry, engine updates to the active one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NDESC; i++) begin
        d_addr_q[i] <= '0;
        d_rng_q[i] <= '0;
        d_ctl_q[i] <= cbd_pkg::BYTE_RST;
        d_s6_q[i] <= cbd_pkg::BYTE_RST;
        d_s7_q[i] <= cbd_pkg::BYTE_RST;
        d_ar_q[i] <= 1'b0;
      end
    end else begin
      if (apb_wr && paddr == cbd_pkg::OFF_ADDR) begin
        d_addr_q[sel_q] <= pwdata[AW-1:0];
        d_ar_q[sel_q] <= 1'b1;
      end
      if (apb_wr && paddr == cbd_pkg::OFF_RANGE) begin
        d_rng_q[sel_q] <= pwdata[RW-1:0];
        d_ar_q[sel_q] <= 1'b1;
      end
      if (apb_wr && paddr == cbd_pkg::OFF_CTRL) begin
        d_ctl_q[sel_q] <= pwdata[7:0];
        d_ctl_q[sel_q][cbd_pkg::CTL_VALID] <= pwdata[cbd_pkg::CTL_VALID]
                                              && d_ar_q[sel_q];
        d_s6_q[sel_q] <= cbd_pkg::BYTE_RST;
        d_s7_q[sel_q] <= cbd_pkg::BYTE_RST;
      end
      if (acc && act_rng != '0) begin
        d_rng_q[act_q] <= act_rng - 1'b1;
      end
      if (st_q == cbd_pkg::CBD_MEM && mem_ack && !fail_any) begin
        d_addr_q[act_q] <= act_addr + 1'b1;
      end
      if (st_q == cbd_pkg::CBD_CPL) begin
        d_s7_q[act_q][cbd_pkg::S7_DONE] <= 1'b1;
        d_s7_q[act_q][cbd_pkg::S7_PRG5] <= lt_q[1];
        d_s7_q[act_q][cbd_pkg::S7_PRG6] <= lt_q[0];
        d_s7_q[act_q][cbd_pkg::S7_IRQ] <= d_ctl_q[act_q][cbd_pkg::CTL_IRQ]
                                          && lvl_q != '0;
        d_s6_q[act_q][cbd_pkg::S6_NAK] <= cpl_err_q[2];
        d_s6_q[act_q][cbd_pkg::S6_PERR] <= cpl_err_q[1];
        d_s6_q[act_q][cbd_pkg::S6_UERR] <= cpl_err_q[0];
        d_s6_q[act_q][cbd_pkg::S6_RESID] <= chan_tx_q ? d_ctl_q[act_q][cbd_pkg::CTL_LB]
                                            : act_rng != '0;
        d_ctl_q[act_q][cbd_pkg::CTL_VALID] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory bus master for single characters.

  // Request fields are held steady until the memory answers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_be_q <= '0;
      mem_wdata_q <= '0;
    end else if (acc && cp_phys) begin
      mem_req_q <= 1'b1;
      mem_we_q <= cp_store;
      mem_addr_q <= act_addr[AW-1:1];
      mem_be_q <= cbd_lane(act_addr[0]);
      mem_wdata_q <= {cp_wchar, cp_wchar};
    end else if (st_q == cbd_pkg::CBD_MEM && (mem_ack || fail_any)) begin
      mem_req_q <= 1'b0;
    end
  end

  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_be = mem_be_q;
  assign mem_wdata = mem_wdata_q;

  // Fetched character comes from the lane that was requested.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rchar_q <= '0;
    end else if (st_q == cbd_pkg::CBD_MEM && mem_ack && !fail_any && !mem_we_q) begin
      rchar_q <= (mem_be_q == cbd_pkg::BE_RIGHT) ? mem_rdata[7:0]
                 : mem_rdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel program answers.

  // One done pulse per accepted instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cmd && !(act_valid && cp_phys)) || nb_skip
                || (st_q == cbd_pkg::CBD_MEM && (mem_ack || fail_any))
                || (st_q == cbd_pkg::CBD_CPL && cpl_nb_q);
    end
  end

  // Last character flag follows the range reaching zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_char_q <= 1'b0;
    end else if (acc) begin
      last_char_q <= act_rng <= RW'(1);
    end
  end

  // Completion interrupt pulse at the assigned level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= st_q == cbd_pkg::CBD_CPL && d_ctl_q[act_q][cbd_pkg::CTL_IRQ]
               && lvl_q != '0;
    end
  end

  assign cp_ready = rdy;
  assign cp_rchar = rchar_q;
  assign cp_done = done_q;
  assign cp_valid = act_valid;
  assign cp_last_block = act_valid && d_ctl_q[act_q][cbd_pkg::CTL_LB];
  assign cp_last_char = last_char_q;
  assign irq_req = irq_q;
  assign irq_level = lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RANGE_DEC: assert property (acc && act_rng != '0 |=>
    d_rng_q[$past(act_q)] == $past(act_rng) - 1'b1)
    else $error("Range did not drop by one.");

  AST_ADDR_HOLD: assert property (acc && !cp_phys |=> act_addr == $past(act_addr))
    else $error("Address moved without a transfer.");

  AST_ADDR_INC: assert property (st_q == cbd_pkg::CBD_MEM && mem_ack && !fail_any |=>
    act_addr == $past(act_addr) + 1'b1)
    else $error("Address did not advance after a transfer.");

  AST_LANE: assert property (acc && cp_phys |=>
    mem_req && mem_be == cbd_lane($past(act_addr[0])))
    else $error("Wrong byte lane.");

  AST_CPL: assert property (st_q == cbd_pkg::CBD_CPL |=>
    d_s7_q[$past(act_q)][cbd_pkg::S7_DONE] && !d_ctl_q[$past(act_q)][cbd_pkg::CTL_VALID])
    else $error("Completion did not set done and clear valid.");

  AST_NAK: assert property (st_q == cbd_pkg::CBD_MEM && mem_nak |=>
    st_q == cbd_pkg::CBD_CPL ##1 d_s6_q[$past(act_q, 2)][cbd_pkg::S6_NAK])
    else $error("Negative acknowledge not recorded.");

  AST_UERR: assert property (st_q == cbd_pkg::CBD_MEM && mem_uerr |=>
    ##1 d_s6_q[$past(act_q, 2)][cbd_pkg::S6_UERR])
    else $error("Uncorrected error not recorded.");

  AST_NB_ADV: assert property (nb_skip |=> act_q == cbd_next($past(act_q)))
    else $error("Pointer did not advance.");

  AST_NB_CPL: assert property (nb_go |=> st_q == cbd_pkg::CBD_CPL ##1
    act_q == cbd_next($past(act_q, 2)) && cp_done)
    else $error("Next block did not complete the active descriptor.");

  AST_CTRL_CLR: assert property (apb_wr && paddr == cbd_pkg::OFF_CTRL |=>
    d_s6_q[$past(sel_q)] == '0 && d_s7_q[$past(sel_q)] == '0)
    else $error("Control write did not clear status.");

  AST_LAST: assert property (acc && act_rng == RW'(1) |=> cp_last_char)
    else $error("Last character flag missing.");

  AST_IRQ: assert property (st_q == cbd_pkg::CBD_CPL && d_ctl_q[act_q][cbd_pkg::CTL_IRQ]
    && lvl_q != '0 |=> irq_req)
    else $error("Completion interrupt missing.");

  COV_STORE: cover property (acc && cp_store && cp_phys ##[1:20] cp_done);
  COV_NB: cover property (nb_go ##2 cp_done);
  COV_NAK: cover property (st_q == cbd_pkg::CBD_MEM && mem_nak);
  COV_STOP: cover property (stop_go);

endmodule

// ==== cbd_mem_model.sv ====
// Main memory on the word-wide bus: one answer per request, with optional error answers.
module cbd_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [22:0] mem_addr,
  input wire logic [1:0] mem_be,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] err_mode,
  input wire logic [3:0] delay,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic mem_nak,
  output logic mem_perr,
  output logic mem_uerr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [3:0] cnt_q;
  logic done_q;

  // Fill each word with a pattern derived from its index.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'(i) ^ 8'h5a, 8'(i) ^ 8'ha5};
    end
  end

  // Answer after the set delay, then wait until the request drops before serving again.
  // Released read data toggles so a late sample never sees a stale character.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      mem_ack <= 1'b0;
      mem_nak <= 1'b0;
      mem_perr <= 1'b0;
      mem_uerr <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      mem_nak <= 1'b0;
      mem_perr <= 1'b0;
      mem_uerr <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
        cnt_q <= 4'h0;
        done_q <= 1'b0;
      end else if (!done_q && cnt_q == delay) begin
        done_q <= 1'b1;
        mem_ack <= err_mode == 2'd0 || err_mode == 2'd2;
        mem_nak <= err_mode == 2'd1;
        mem_perr <= err_mode == 2'd2 && !mem_we;
        mem_uerr <= err_mode == 2'd3;
        if (!mem_we) begin
          mem_rdata <= mem[mem_addr[7:0]];
        end
        if (mem_we && err_mode == 2'd0 && mem_be[1]) begin
          mem[mem_addr[7:0]][15:8] <= mem_wdata[15:8];
        end
        if (mem_we && err_mode == 2'd0 && mem_be[0]) begin
          mem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
        end
      end else if (!done_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ==== channel_buffer_descriptor_dma_bench.sv ====
// Self-checking bench for the descriptor engine with a memory model on its bus.
module channel_buffer_descriptor_dma_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] LD = 4'b1000;
  localparam logic [3:0] SP = 4'b0110;
  localparam logic [3:0] NB = 4'b0001;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, mem_req, mem_we, mem_ack, mem_nak, mem_perr, mem_uerr;
  logic [22:0] mem_addr;
  logic [1:0] mem_be;
  logic [15:0] mem_wdata, mem_rdata;
  logic cp_load = 1'b0, cp_store = 1'b0, cp_phys = 1'b0, cp_next_block = 1'b0;
  logic [7:0] cp_wchar = 8'h00, cp_rchar;
  logic [1:0] cp_lt_bits = 2'b00, err_mode = 2'b00;
  logic [3:0] delay = 4'h0;
  logic cp_ready, cp_done, cp_valid, cp_last_block, cp_last_char, irq_req;
  logic [cbd_pkg::LVL_W-1:0] irq_level;
  int mismatches = 0, num_checks = 0, irq_count = 0;

  // Clock, pulse counter and hang watchdog.
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (irq_req === 1'b1) irq_count++;
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  cbd_engine #(.NDESC(4), .AW(24), .RW(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_be,
    .mem_wdata, .mem_rdata, .mem_ack, .mem_nak, .mem_perr, .mem_uerr, .cp_ready, .cp_load,
    .cp_store, .cp_phys, .cp_wchar, .cp_next_block, .cp_lt_bits, .cp_rchar, .cp_done,
    .cp_valid, .cp_last_block, .cp_last_char, .irq_req, .irq_level);
  cbd_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .err_mode, .delay, .mem_rdata, .mem_ack, .mem_nak, .mem_perr, .mem_uerr);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Shared tasks for comparison, bus cycles and channel commands.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Only the watchdog ends a wait for the slave's answer.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cmd(input logic [3:0] k, input logic [7:0] ch, input logic [1:0] bits);
    while (cp_ready !== 1'b1) begin
      @(posedge pclk);
    end
    {cp_load, cp_store, cp_phys, cp_next_block} <= k;
    cp_wchar <= ch;
    cp_lt_bits <= bits;
    @(posedge pclk);
    {cp_load, cp_store, cp_phys, cp_next_block} <= 4'b0000;
    do begin
      @(posedge pclk);
    end while (cp_done !== 1'b1);
  endtask

  task automatic setup(input int i, input logic [23:0] a, input logic [15:0] r,
                       input logic [7:0] c);
    apb(1'b1, cbd_pkg::OFF_SEL, 32'(i));
    apb(1'b1, cbd_pkg::OFF_ADDR, 32'(a));
    apb(1'b1, cbd_pkg::OFF_RANGE, 32'(r));
    apb(1'b1, cbd_pkg::OFF_CTRL, 32'(c));
    rdchk(cbd_pkg::OFF_STAT, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Reset state, refused valid bit without a prior address write, unmapped access.
  task automatic t_reset;
    chk(32'(cp_ready), 32'h1);
    apb(1'b1, cbd_pkg::OFF_CTRL, 32'h40);
    rdchk(cbd_pkg::OFF_CTRL, 32'h0);
    chk(32'(cp_valid), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(err), 32'h1);
  endtask

  // Receive from an odd start with a skipped store, then next block with a program bit.
  task automatic t_rx;
    apb(1'b1, cbd_pkg::OFF_CHAN, 32'h4);
    setup(0, 24'h000101, 16'h3, 8'hc0);
    setup(1, 24'h000200, 16'h4, 8'h40);
    chk(32'(cp_valid), 32'h1);
    apb(1'b1, cbd_pkg::OFF_SEL, 32'h0);
    apb(1'b1, cbd_pkg::OFF_ADDR, 32'h0);
    chk(32'(err), 32'h1);
    delay <= 4'h3;
    cmd(SP, 8'h41, 2'b00);
    cmd(SP & 4'b1100, 8'h55, 2'b00);
    cmd(SP, 8'h42, 2'b00);
    chk({16'h0, u_mem.mem[8'h80]}, 32'hda41);
    chk({16'h0, u_mem.mem[8'h81]}, 32'h4224);
    chk(32'(cp_last_char), 32'h1);
    rdchk(cbd_pkg::OFF_ADDR, 32'h103);
    rdchk(cbd_pkg::OFF_RANGE, 32'h0);
    cmd(NB, 8'h00, 2'b10);
    rdchk(cbd_pkg::OFF_STAT, 32'h5400);
    rdchk(cbd_pkg::OFF_CTRL, 32'h80);
    rdchk(cbd_pkg::OFF_INFO, 32'h5);
    chk(32'(irq_count), 32'h1);
    chk(32'(irq_level), 32'h1);
  endtask

  // Transmit two fetched characters and one skipped load, ended early.
  task automatic t_tx;
    apb(1'b1, cbd_pkg::OFF_CHAN, 32'h2);
    apb(1'b1, cbd_pkg::OFF_SEL, 32'h1);
    delay <= 4'h0;
    cmd(LD | 4'b0010, 8'h00, 2'b00);
    chk(32'(cp_rchar), 32'h5a);
    cmd(LD | 4'b0010, 8'h00, 2'b00);
    chk(32'(cp_rchar), 32'ha5);
    cmd(LD, 8'h00, 2'b00);
    rdchk(cbd_pkg::OFF_ADDR, 32'h202);
    cmd(NB, 8'h00, 2'b01);
    rdchk(cbd_pkg::OFF_STAT, 32'h1200);
    rdchk(cbd_pkg::OFF_RANGE, 32'h1);
    chk(32'(irq_count), 32'h1);
  endtask

  // Each memory error answer ends the descriptor with its own status bit.
  task automatic t_err;
    for (int e = 1; e < 4; e++) begin
      setup(2, 24'h000300, 16'h2, 8'h40);
      err_mode <= 2'(e);
      cmd(LD | 4'b0010, 8'h00, 2'b00);
      err_mode <= 2'b00;
      rdchk(cbd_pkg::OFF_STAT, 32'h1000 | (32'h8 >> e));
      rdchk(cbd_pkg::OFF_RANGE, 32'h1);
      chk(32'(cp_valid), 32'h0);
    end
    cmd(NB, 8'h00, 2'b00);
    rdchk(cbd_pkg::OFF_INFO, 32'h3);
  endtask

  // Software stop in mid-buffer leaves a residue on receive.
  task automatic t_stop;
    apb(1'b1, cbd_pkg::OFF_CHAN, 32'h0);
    setup(3, 24'h000401, 16'h5, 8'h60);
    chk(32'(cp_last_block), 32'h1);
    cmd(SP, 8'h33, 2'b00);
    apb(1'b1, cbd_pkg::OFF_CHAN, 32'h1);
    repeat (4) @(posedge pclk);
    rdchk(cbd_pkg::OFF_STAT, 32'h1020);
    rdchk(cbd_pkg::OFF_RANGE, 32'h4);
    chk(32'(cp_valid), 32'h0);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for sixteen cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rx();
    t_tx();
    t_err();
    t_stop();
    stop_test();
  end
endmodule
